// [core/quad_dac_i2c_command_decoder.sv]
// two-wire target front end: address, high speed mode, command word assembly
`timescale 1ns/100ps
`include "dac_cmd_params.svh"

module quad_dac_i2c_command_decoder import dac_cmd_pkg::*; #(
  parameter int DAC_BITS = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [3:0] addr_strap_in,
  input wire logic clear_input_n_in,
  output logic hs_mode_out,
  output logic cmd_valid_out,
  output logic [2:0] opcode_out,
  output logic [3:0] channel_mask_out,
  output logic [15:0] code_out,
  output logic [3:0] load_input_mask_out,
  output logic [3:0] update_output_mask_out,
  output logic power_ctrl_out,
  output logic soft_reset_out,
  output logic load_mask_setup_out,
  output logic ref_setup_out
);
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic sda_oe_q;
  logic hs_q;
  logic rw_q;
  logic [6:0] own_addr_q;
  logic [1:0] pos_q;
  logic [7:0] cmd_q;
  logic [7:0] hi_q;
  logic word_fire_q;
  logic [23:0] word_q;
  logic [15:0] last_q;
  logic [7:0] out_q;
  logic rd_idx_q;
  logic mack_q;
  logic byte_done;
  logic hs_code;
  logic addr_ok;

  // ----------------------------------------
  // bus line events
  // ----------------------------------------
  i2c_line_monitor u_mon (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_det),
    .stop_out(stop_det)
  );

  function automatic logic addr_accept(input logic [7:0] b, input logic [6:0] own);
    // general call and ten-bit headers never match own address
    addr_accept = (b[7:1] == own) || (b[7:1] == `BCAST_ADDR && !b[0]);
  endfunction

  always_comb begin
    byte_done = scl_fall && cnt_q == `BYTE_BITS;
    hs_code = sh_q[7:3] == `HS_CODE_TOP;
    addr_ok = !hs_code && addr_accept(sh_q, own_addr_q);
  end

  // straps sampled while reset is held
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      own_addr_q <= {`ADDR_TOP_BITS, addr_strap_in};
    end
  end

  // ----------------------------------------
  // bit counting and shifting
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || start_det || stop_det) begin
      cnt_q <= 4'h0;
    end else if (byte_done) begin
      cnt_q <= 4'h0;
    end else if (scl_rise && state_q inside {ST_ADDR, ST_WR_BYTE, ST_RD_BYTE}) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sh_q <= 8'h00;
    end else if (scl_rise) begin
      sh_q <= {sh_q[6:0], sda_in};
    end
  end

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || stop_det) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_ADDR;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
        end
        ST_ADDR: begin
          if (byte_done) begin
            state_q <= addr_ok ? ST_ADDR_ACK : ST_SKIP;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_q <= rw_q ? ST_RD_BYTE : ST_WR_BYTE;
          end
        end
        ST_WR_BYTE: begin
          if (byte_done) begin
            state_q <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            state_q <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (byte_done) begin
            state_q <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          if (scl_fall) begin
            state_q <= (mack_q && !rd_idx_q) ? ST_RD_BYTE : ST_SKIP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rw_q <= 1'b0;
    end else if (state_q == ST_ADDR && byte_done) begin
      rw_q <= sh_q[0];
    end
  end

  // ----------------------------------------
  // high speed mode
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hs_q <= 1'b0;
    end else if (state_q == ST_ADDR && byte_done && hs_code) begin
      hs_q <= 1'b1;
    end else if (stop_det) begin
      hs_q <= 1'b0;
    end else if (!clear_input_n_in) begin
      hs_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // data line drive
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || start_det || stop_det) begin
      sda_oe_q <= 1'b0;
      out_q <= 8'h00;
      rd_idx_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_ADDR: begin
          if (byte_done) begin
            sda_oe_q <= addr_ok;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= rw_q && !last_q[15];
            out_q <= last_q[15:8];
            rd_idx_q <= 1'b0;
          end
        end
        ST_WR_BYTE: begin
          if (byte_done) begin
            sda_oe_q <= 1'b1;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
          end
        end
        ST_RD_BYTE: begin
          if (byte_done) begin
            sda_oe_q <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_q <= !out_q[6];
            out_q <= {out_q[6:0], 1'b0};
          end
        end
        ST_RD_ACK: begin
          if (scl_fall && mack_q && !rd_idx_q) begin
            sda_oe_q <= !last_q[7];
            out_q <= last_q[7:0];
            rd_idx_q <= 1'b1;
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mack_q <= 1'b0;
    end else if (state_q == ST_RD_ACK && scl_rise) begin
      mack_q <= !sda_in;
    end
  end

  // ----------------------------------------
  // command word assembly
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pos_q <= `POS_CMD;
      cmd_q <= 8'h00;
      hi_q <= 8'h00;
      word_q <= 24'h00_0000;
      word_fire_q <= 1'b0;
      last_q <= 16'h0000;
    end else begin
      word_fire_q <= 1'b0;
      if (state_q == ST_ADDR && byte_done) begin
        pos_q <= `POS_CMD;
      end else if (state_q == ST_WR_BYTE && byte_done) begin
        unique case (pos_q)
          `POS_CMD: begin
            cmd_q <= sh_q;
            pos_q <= `POS_HIGH;
          end
          `POS_HIGH: begin
            hi_q <= sh_q;
            pos_q <= `POS_LOW;
          end
          default: begin
            word_q <= {cmd_q, hi_q, sh_q};
            word_fire_q <= 1'b1;
            last_q <= {hi_q, sh_q};
            // select bit keeps the command for following pairs
            pos_q <= cmd_q[`SEL_IN_CMD] ? `POS_HIGH : `POS_CMD;
          end
        endcase
      end
    end
  end

  cmd_word_decoder #(.DAC_BITS(DAC_BITS)) u_dec (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .word_valid_in(word_fire_q),
    .word_in(word_q),
    .cmd_valid_out(cmd_valid_out),
    .opcode_out(opcode_out),
    .channel_mask_out(channel_mask_out),
    .code_out(code_out),
    .load_input_mask_out(load_input_mask_out),
    .update_output_mask_out(update_output_mask_out),
    .power_ctrl_out(power_ctrl_out),
    .soft_reset_out(soft_reset_out),
    .load_mask_setup_out(load_mask_setup_out),
    .ref_setup_out(ref_setup_out)
  );

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_q;
  assign hs_mode_out = hs_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_addr_byte;
    state_q == ST_ADDR && byte_done && !start_det && !stop_det;
  endsequence

  sequence seq_hs_code;
    seq_addr_byte ##0 hs_code;
  endsequence

  AST_HS_NO_ACK: assert property (seq_hs_code |=> !sda_oe_q && hs_q && state_q == ST_SKIP)
    else $error("high speed code acknowledged or mode not entered");
  AST_HS_STOP_EXIT: assert property (stop_det |=> !hs_q && state_q == ST_IDLE)
    else $error("high speed mode kept past stop");
  AST_HS_CLEAR_EXIT: assert property ((hs_q && !clear_input_n_in && !byte_done) |=> !hs_q)
    else $error("clear did not leave high speed mode");
  AST_ADDR_ACK: assert property ((seq_addr_byte ##0 addr_ok)
    |=> (sda_oe_q && state_q == ST_ADDR_ACK) ##1 sda_oe_q)
    else $error("own address not acknowledged");
  AST_BCAST_READ_NACK: assert property ((seq_addr_byte ##0 sh_q == {`BCAST_ADDR, 1'b1})
    |=> !sda_oe_q ##1 !sda_oe_q)
    else $error("broadcast read acknowledged");
  AST_BCAST_WRITE_ACK: assert property ((seq_addr_byte ##0 sh_q == {`BCAST_ADDR, 1'b0})
    |=> sda_oe_q && state_q == ST_ADDR_ACK)
    else $error("broadcast write not acknowledged");
  AST_GCALL_NACK: assert property ((seq_addr_byte ##0 sh_q[7:1] == `GCALL_ADDR) |=> !sda_oe_q)
    else $error("general call acknowledged");
  AST_SEL_REPEAT: assert property ((word_fire_q && word_q[`SEL_BIT]) |-> pos_q == `POS_HIGH)
    else $error("select one did not keep command");
  AST_SEL_BLOCK: assert property ((word_fire_q && !word_q[`SEL_BIT]) |-> pos_q == `POS_CMD)
    else $error("select zero did not expect new command");
  AST_WORD_TO_DECODE: assert property (word_fire_q && !word_q[`OP_MSB]
    && word_q[`CH_MSB:`CH_LSB] inside {3'h0, 3'h1, 3'h2, 3'h3, `CH_ALL}
    |=> cmd_valid_out && opcode_out == $past(word_q[`OP_MSB:`OP_LSB]))
    else $error("assembled word not passed to decode");
endmodule

// [core/dac_cmd_params.svh]
// field positions, bus codes and counts of the serial command word
`ifndef DAC_CMD_PARAMS_SVH
`define DAC_CMD_PARAMS_SVH

`define WORD_W 24
`define RSV_BIT 23
`define SEL_BIT 22
`define SEL_IN_CMD 6
`define OP_MSB 21
`define OP_LSB 19
`define CH_MSB 18
`define CH_LSB 16
`define DATA_MSB 15
`define BYTE_BITS 4'h8
`define HS_CODE_TOP 5'h01
`define BCAST_ADDR 7'h08
`define GCALL_ADDR 7'h00
`define ADDR_TOP_BITS 3'h1
`define CH_ALL 3'h7
`define POS_CMD 2'h0
`define POS_HIGH 2'h1
`define POS_LOW 2'h2

`endif

// [core/dac_cmd_pkg.sv]
// types shared by the serial command front end
package dac_cmd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_SKIP
  } state_t;

  typedef enum logic [2:0] {
    OP_WRITE_INPUT = 3'h0,
    OP_UPDATE_OUTPUT = 3'h1,
    OP_WRITE_UPDATE_ALL = 3'h2,
    OP_WRITE_UPDATE = 3'h3,
    OP_POWER = 3'h4,
    OP_RESET = 3'h5,
    OP_LOAD_MASK = 3'h6,
    OP_REF_SETUP = 3'h7
  } opcode_t;
endpackage

// [core/i2c_line_monitor.sv]
// edge and start/stop detection on the two-wire bus lines
`timescale 1ns/100ps
module i2c_line_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise_out = scl_in && !scl_q;
  assign scl_fall_out = !scl_in && scl_q;
  // data edges while clock stays high
  assign start_out = scl_in && scl_q && sda_q && !sda_in;
  assign stop_out = scl_in && scl_q && !sda_q && sda_in;
endmodule

// [core/cmd_word_decoder.sv]
// decode of a complete 24-bit command word into channel actions
`timescale 1ns/100ps
`include "dac_cmd_params.svh"
module cmd_word_decoder import dac_cmd_pkg::*; #(
  parameter int DAC_BITS = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic word_valid_in,
  input wire logic [23:0] word_in,
  output logic cmd_valid_out,
  output logic [2:0] opcode_out,
  output logic [3:0] channel_mask_out,
  output logic [15:0] code_out,
  output logic [3:0] load_input_mask_out,
  output logic [3:0] update_output_mask_out,
  output logic power_ctrl_out,
  output logic soft_reset_out,
  output logic load_mask_setup_out,
  output logic ref_setup_out
);
  if (DAC_BITS != 16 && DAC_BITS != 14 && DAC_BITS != 12) begin : g_bad_bits
    $error("DAC_BITS must be 12, 14 or 16");
  end

  localparam logic [15:0] CODE_MASK = 16'(32'hFFFF << (16 - DAC_BITS));

  function automatic logic [3:0] chan_mask(input logic [2:0] ch);
    unique case (ch)
      3'h0: chan_mask = 4'h1;
      3'h1: chan_mask = 4'h2;
      3'h2: chan_mask = 4'h4;
      3'h3: chan_mask = 4'h8;
      `CH_ALL: chan_mask = 4'hF;
      default: chan_mask = 4'h0;
    endcase
  endfunction

  opcode_t op;
  logic [3:0] msk;
  logic data_op;
  logic accept;

  always_comb begin
    // reserved top bit is not looked at
    op = opcode_t'(word_in[`OP_MSB:`OP_LSB]);
    msk = chan_mask(word_in[`CH_MSB:`CH_LSB]);
    data_op = !word_in[`OP_MSB];
    accept = word_valid_in && (!data_op || msk != 4'h0);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      opcode_out <= 3'h0;
      channel_mask_out <= 4'h0;
      code_out <= 16'h0000;
      load_input_mask_out <= 4'h0;
      update_output_mask_out <= 4'h0;
      power_ctrl_out <= 1'b0;
      soft_reset_out <= 1'b0;
      load_mask_setup_out <= 1'b0;
      ref_setup_out <= 1'b0;
    end else begin
      cmd_valid_out <= accept;
      load_input_mask_out <= 4'h0;
      update_output_mask_out <= 4'h0;
      power_ctrl_out <= accept && op == OP_POWER;
      soft_reset_out <= accept && op == OP_RESET;
      load_mask_setup_out <= accept && op == OP_LOAD_MASK;
      ref_setup_out <= accept && op == OP_REF_SETUP;
      if (accept) begin
        opcode_out <= op;
        channel_mask_out <= msk;
        // left-justified code, unused low bits dropped
        code_out <= data_op ? (word_in[`DATA_MSB:0] & CODE_MASK)
                            : word_in[`DATA_MSB:0];
        unique case (op)
          OP_WRITE_INPUT: load_input_mask_out <= msk;
          OP_UPDATE_OUTPUT: update_output_mask_out <= msk;
          OP_WRITE_UPDATE_ALL: begin
            load_input_mask_out <= msk;
            update_output_mask_out <= 4'hF;
          end
          OP_WRITE_UPDATE: begin
            load_input_mask_out <= msk;
            update_output_mask_out <= msk;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_BAD_CHAN_DROP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (word_valid_in && !word_in[`OP_MSB] && word_in[`CH_MSB:`CH_LSB] inside {3'h4, 3'h5, 3'h6})
    |=> !cmd_valid_out && load_input_mask_out == 4'h0 && update_output_mask_out == 4'h0)
    else $error("data command with bad channel was acted on");
  AST_CODE_JUSTIFY: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cmd_valid_out && !opcode_out[2]) |-> (code_out & ~CODE_MASK) == 16'h0000)
    else $error("unused low code bits not cleared");
  AST_SOFT_STROBE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (accept && op == OP_WRITE_UPDATE_ALL) |=> update_output_mask_out == 4'hF
      && load_input_mask_out == $past(msk))
    else $error("software load strobe did not update all channels");
endmodule

// [sim/i2c_ctrl_model.sv]
// two-wire bus controller model facing the command front end
`timescale 1ns/100ps
module i2c_ctrl_model (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  localparam int QTR = 4;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // ----------------------------------------
  // line timing
  // ----------------------------------------
  task automatic wait_q();
    repeat (QTR) @(negedge sys_clk_in);
  endtask

  // sda moves only a quarter after scl falls
  task automatic bit_cyc(input logic val, output logic seen);
    sda_low_out = ~val;
    wait_q();
    scl_out = 1'b1;
    wait_q();
    seen = sda_in;
    scl_out = 1'b0;
    wait_q();
  endtask

  // start and repeated start alike
  task automatic start();
    sda_low_out = 1'b0;
    wait_q();
    scl_out = 1'b1;
    wait_q();
    sda_low_out = 1'b1;
    wait_q();
    scl_out = 1'b0;
    wait_q();
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    wait_q();
    scl_out = 1'b1;
    wait_q();
    sda_low_out = 1'b0;
    wait_q();
  endtask

  // ----------------------------------------
  // bytes
  // ----------------------------------------
  // also carries the high speed code before a repeated start
  task automatic wbyte(input logic [7:0] data, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(data[i], s);
    end
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic master_ack, output logic [7:0] data);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, data[i]);
    end
    bit_cyc(~master_ack, s);
  endtask
endmodule

// [sim/testbench.sv]
// self-checking bench of the two-wire command front end
`timescale 1ns/100ps
module testbench;
  import dac_cmd_pkg::*;
  localparam int DAC_BITS = 12;
  logic sys_clk_in, rst_in, scl_w, m_low, sda_w, dut_oe, sda_o, clr_n, hs;
  logic [3:0] strap, chm, ldm, upm;
  logic cmd_v, pw, sr, lm, rf;
  logic [2:0] op_o;
  logic [15:0] code_o, last_d;
  logic [34:0] exp_q[$];
  logic [34:0] seen_vec;
  logic [7:0] rd_hi, rd_lo;
  logic [2:0] ch_tab[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  integer seed, miscompares, num_checks;

  // open-drain wire with pull-up: low while either side pulls it to its low level
  assign sda_w = ~(m_low | (dut_oe & ~sda_o));
  assign seen_vec = {op_o, (op_o[2] ? 4'h0 : chm), code_o, ldm, upm, rf, lm, sr, pw};

  quad_dac_i2c_command_decoder #(.DAC_BITS(DAC_BITS)) dut (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(dut_oe),
    .addr_strap_in(strap), .clear_input_n_in(clr_n), .hs_mode_out(hs), .cmd_valid_out(cmd_v),
    .opcode_out(op_o), .channel_mask_out(chm), .code_out(code_o), .load_input_mask_out(ldm),
    .update_output_mask_out(upm), .power_ctrl_out(pw), .soft_reset_out(sr),
    .load_mask_setup_out(lm), .ref_setup_out(rf));
  i2c_ctrl_model m (.sys_clk_in(sys_clk_in), .sda_in(sda_w), .scl_out(scl_w),
    .sda_low_out(m_low));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [34:0] expect_of(input logic [7:0] cmd, input logic [15:0] d);
    logic [2:0] op;
    logic [3:0] ch, ld, up, pl;
    logic [15:0] c;
    op = cmd[5:3];
    ch = (cmd[2:0] == 3'h7) ? 4'hf : 4'h1 << cmd[1:0];
    c = d;
    ld = 4'h0;
    up = 4'h0;
    pl = 4'h0;
    if (!op[2]) c = d & (16'hffff << (16 - DAC_BITS));
    case (op)
      OP_WRITE_INPUT: ld = ch;
      OP_UPDATE_OUTPUT: up = ch;
      OP_WRITE_UPDATE_ALL: begin
        ld = ch;
        up = 4'hf;
      end
      OP_WRITE_UPDATE: begin
        ld = ch;
        up = ch;
      end
      default: begin
        pl = 4'h1 << op[1:0];
        ch = 4'h0;
      end
    endcase
    return {op, ch, c, ld, up, pl};
  endfunction

  always @(negedge sys_clk_in) begin
    if (cmd_v === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected command", 35'h1, 35'h0);
      else check("command", seen_vec, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic wbyte_chk(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.wbyte(b, a);
    check("ack", 35'(a), 35'(exp_ack));
  endtask

  // reserved top bit always written as zero
  task automatic send_word(input logic [7:0] cmd, input logic [15:0] d, input logic pair);
    if (!pair) wbyte_chk(cmd, 1'b1);
    if (cmd[5] || cmd[2:0] == 3'h7 || !cmd[2]) exp_q.push_back(expect_of(cmd, d));
    wbyte_chk(d[15:8], 1'b1);
    wbyte_chk(d[7:0], 1'b1);
  endtask

  task automatic do_reset(input logic [3:0] s);
    @(negedge sys_clk_in);
    rst_in = 1'b1;
    strap = s;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
  endtask

  initial begin
    #1000000;
    miscompares++;
    results();
  end

  initial begin
    seed = 36375;
    miscompares = 0;
    num_checks = 0;
    clr_n = 1'b1;
    rst_in = 1'b1;
    strap = 4'h5;
    do_reset(4'h5);
    check("hs after reset", 35'(hs), 35'h0);
    // high speed entry, exit on stop
    m.start();
    wbyte_chk(8'h0d, 1'b0);
    check("hs set", 35'(hs), 35'h1);
    m.start();
    wbyte_chk(8'h2a, 1'b1);
    send_word({2'b00, OP_WRITE_UPDATE, 3'h2}, 16'($random(seed)), 1'b0);
    check("hs held", 35'(hs), 35'h1);
    m.stop();
    check("hs after stop", 35'(hs), 35'h0);
    // clear drops high speed mode
    m.start();
    wbyte_chk(8'h08, 1'b0);
    m.start();
    wbyte_chk(8'h2a, 1'b1);
    @(negedge sys_clk_in);
    clr_n = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check("hs after clear", 35'(hs), 35'h0);
    clr_n = 1'b1;
    // every opcode, several channels, one write
    for (int op = 0; op < 8; op++) begin
      send_word({2'b00, 3'(op), ch_tab[op % 5]}, 16'($random(seed)), 1'b0);
    end
    send_word({2'b00, OP_WRITE_INPUT, 3'h5}, 16'($random(seed)), 1'b0);
    send_word({2'b01, OP_WRITE_INPUT, 3'h1}, 16'($random(seed)), 1'b0);
    send_word({2'b01, OP_WRITE_INPUT, 3'h1}, 16'($random(seed)), 1'b1);
    last_d = 16'($random(seed)) & 16'hfff0;
    send_word({2'b01, OP_WRITE_INPUT, 3'h1}, last_d, 1'b1);
    m.stop();
    // readback of the last word
    m.start();
    wbyte_chk(8'h2b, 1'b1);
    m.rbyte(1'b1, rd_hi);
    m.rbyte(1'b0, rd_lo);
    m.stop();
    check("readback", 35'({rd_hi, rd_lo}), 35'(last_d));
    // refused addresses
    m.start();
    wbyte_chk(8'h00, 1'b0);
    m.stop();
    m.start();
    wbyte_chk(8'hf0, 1'b0);
    m.stop();
    m.start();
    wbyte_chk(8'h11, 1'b0);
    m.stop();
    // new straps: old address refused, broadcast still taken
    do_reset(4'ha);
    m.start();
    wbyte_chk(8'h2a, 1'b0);
    m.stop();
    m.start();
    wbyte_chk(8'h10, 1'b1);
    send_word({2'b00, OP_WRITE_UPDATE_ALL, 3'h7}, 16'($random(seed)), 1'b0);
    m.stop();
    repeat (20) @(negedge sys_clk_in);
    check("pending commands", 35'(exp_q.size()), 35'h0);
    results();
  end
endmodule
